// ---- charger_protection_control.sv ----
// Charger protection control: over-voltage cut-off, power limiter, reverse
// supply protection and trickle source selection, with an Avalon-MM slave.
// Assumes synchronous active-high reset and comparators from analog blocks.
// How it works
// - On raw charger over-voltage open both series FETs and close battery FET.
// - Resume after over-voltage absent beyond 10 ms, restoring programmed settings.
// - Over-voltage raises charger fault flag and sets fault status to 01.
// - FET control acts directly; any synchronised pulse also sets the fault state.
// - VBUS over-voltage disconnects USB circuitry and raises its flag.
// - Over-budget limiter duty-cycles series FETs and forces battery FET on.
// - Limiter updates its duty decision every 500 ms period.
// - If even 10 % duty is too much, disable path and raise fault 01.
// - Budget select 00/01/10/11 gives 600/800/1000/1200 mW, reset 00.
// - Limiter disable bit turns the limiter off; software then estimates.
// - Limiter is off in serial-path factory mode and reverse mode.
// - 1500 ms blanking after charge enable, still faulting below minimum duty.
// - Reverse enable bit routes battery through charge path to accessory.
// - Reverse short slow 1.0 ms or fast 100 us disables path, raises flag.
// - Reverse current from accessory disables reverse path, raises flag.
// - Trickle current 40 mA below safe-charge, 80 mA up to safe-operate.
// - In software charging mode the trickle enable bit turns the source on.
// - Read-only config sense bit reads 1 for serial path, 0 single.
//
// Register access over Avalon-MM and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module charger_protection_control #(
   parameter int unsigned OV_DEBOUNCE_CYC = charger_protection_pkg::OV_DEBOUNCE_CYC,
   parameter int unsigned CONTROL_PERIOD_CYC = charger_protection_pkg::CONTROL_PERIOD_CYC,
   parameter int unsigned BLANKING_CYC = charger_protection_pkg::BLANKING_CYC,
   parameter int unsigned SLOW_SHORT_CYC = charger_protection_pkg::SLOW_SHORT_CYC,
   parameter int unsigned FAST_SHORT_CYC = charger_protection_pkg::FAST_SHORT_CYC
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic raw_charger_overvoltage,
   input wire logic vbus_overvoltage,
   input wire logic [15:0] pass_power_mw,
   input wire logic short_slow_threshold,
   input wire logic short_fast_threshold,
   input wire logic accessory_reverse_current,
   input wire logic below_safe_charge_threshold,
   input wire logic below_safe_operate_threshold,
   input wire logic trickle_request,
   input wire logic system_fet_request,
   input wire logic charge_path_config_sense,
   output logic series_pass_fet_a,
   output logic series_pass_fet_b,
   output logic battery_system_fet,
   output logic usb_disconnect,
   output logic accessory_path_on,
   output logic trickle_source_on,
   output logic trickle_high_current,
   output logic [3:0] charge_current_setting,
   output logic [2:0] charge_voltage_setting,
   output logic charger_irq
);
   localparam int unsigned SLOT_CYC = CONTROL_PERIOD_CYC / 10;

   // Synchronised comparators
   logic ov_absent, ov_absent_held, vbus_ov, slow_lvl, slow_held, fast_lvl, fast_held;
   logic revcur, below_min, below_on, trickle_req, serial_path;

   sync_persist #(.COUNT(OV_DEBOUNCE_CYC), .INIT(1'b1)) u_ov (.clk(clk), .reset(reset),
      .comparator(!raw_charger_overvoltage), .level(ov_absent), .held(ov_absent_held));
   sync_persist #(.COUNT(1)) u_vbus (.clk(clk), .reset(reset),
      .comparator(vbus_overvoltage), .level(vbus_ov), .held());
   sync_persist #(.COUNT(SLOW_SHORT_CYC)) u_slow (.clk(clk), .reset(reset),
      .comparator(short_slow_threshold), .level(slow_lvl), .held(slow_held));
   sync_persist #(.COUNT(FAST_SHORT_CYC)) u_fast (.clk(clk), .reset(reset),
      .comparator(short_fast_threshold), .level(fast_lvl), .held(fast_held));
   sync_persist #(.COUNT(1)) u_rev (.clk(clk), .reset(reset),
      .comparator(accessory_reverse_current), .level(revcur), .held());
   sync_persist #(.COUNT(1)) u_min (.clk(clk), .reset(reset),
      .comparator(below_safe_charge_threshold), .level(below_min), .held());
   sync_persist #(.COUNT(1)) u_on (.clk(clk), .reset(reset),
      .comparator(below_safe_operate_threshold), .level(below_on), .held());
   sync_persist #(.COUNT(1)) u_trk (.clk(clk), .reset(reset),
      .comparator(trickle_request), .level(trickle_req), .held());
   sync_persist #(.COUNT(1)) u_cfg (.clk(clk), .reset(reset),
      .comparator(charge_path_config_sense), .level(serial_path), .held());

   // Register state
   logic [7:0] control_r, control_nxt;
   logic [6:0] setting_r, setting_nxt;
   logic [3:0] flags_r, flags_nxt, mask_r, mask_nxt;
   logic [31:0] readdata_r, readdata_nxt;
   logic wait_r, wait_nxt;
   // Protection state
   logic ov_fault_r, ov_fault_nxt, power_budget_select_fault_r, power_budget_select_fault_nxt, rev_fault_r, rev_fault_nxt;
   logic charge_on_d_r, blank_active;
   logic [31:0] blank_cnt_r, blank_cnt_nxt, period_cnt_r, period_cnt_nxt;
   logic [3:0] duty_r, duty_nxt, est_duty;
   logic [1:0] fault_status_r, fault_status_nxt;
   // Output flops
   logic fet_ab_r, fet_ab_nxt, sys_fet_r, sys_fet_nxt, usb_disc_r, acc_r, acc_nxt;
   logic trk_on_r, trk_on_nxt, trk_hi_r, trk_hi_nxt, irq_r;
   logic [3:0] cur_r, cur_nxt;
   logic [2:0] volt_r, volt_nxt;

   logic ov_now, charge_on, rev_on, lim_act, pwm_on, lim_chop;
   logic [11:0] budget_mw;
   logic [3:0] set_flags;
   logic bus_go;

   assign ov_now = !ov_absent;
   assign charge_on = control_r[charger_protection_pkg::CHARGE_EN_BIT] && !ov_fault_r
                      && !power_budget_select_fault_r && !control_r[charger_protection_pkg::REVERSE_BIT];
   assign rev_on = control_r[charger_protection_pkg::REVERSE_BIT] && !rev_fault_r;
   assign lim_act = charge_on && !control_r[charger_protection_pkg::LIMITER_DISABLE_BIT]
                    && !control_r[charger_protection_pkg::FACTORY_BIT];
   assign blank_active = (blank_cnt_r != 32'h0);
   assign pwm_on = (period_cnt_r < 32'(duty_r) * SLOT_CYC);
   assign lim_chop = lim_act && !blank_active && (duty_r != charger_protection_pkg::DUTY_FULL);

   // Budget lookup and duty estimate: largest tenth d with power*d <= budget*10
   always_comb begin
      case (control_r[charger_protection_pkg::BUDGET_LSB +: 2])
         2'h0: budget_mw = charger_protection_pkg::BUDGET_0_MW;
         2'h1: budget_mw = charger_protection_pkg::BUDGET_1_MW;
         2'h2: budget_mw = charger_protection_pkg::BUDGET_2_MW;
         default: budget_mw = charger_protection_pkg::BUDGET_3_MW;
      endcase
      est_duty = 4'h0;
      for (int d = 1; d <= 10; d++) begin
         if (20'(pass_power_mw) * 20'(d) <= 20'(budget_mw) * 20'ha) begin
            est_duty = 4'(d);
         end
      end
   end

   // Protection and limiter next state
   always_comb begin
      ov_fault_nxt = ov_fault_r;
      if (ov_now) begin
         ov_fault_nxt = 1'b1;
      end else if (ov_absent_held) begin
         ov_fault_nxt = 1'b0;
      end
      power_budget_select_fault_nxt = power_budget_select_fault_r;
      if (!control_r[charger_protection_pkg::CHARGE_EN_BIT]) begin
         power_budget_select_fault_nxt = 1'b0;
      end else if (lim_act && est_duty < charger_protection_pkg::DUTY_MIN) begin
         power_budget_select_fault_nxt = 1'b1;
      end
      rev_fault_nxt = rev_fault_r;
      if (!control_r[charger_protection_pkg::REVERSE_BIT]) begin
         rev_fault_nxt = 1'b0;
      end else if (slow_held || fast_held || revcur) begin
         rev_fault_nxt = 1'b1;
      end
      blank_cnt_nxt = blank_cnt_r;
      if (!charge_on) begin
         blank_cnt_nxt = 32'h0;
      end else if (!charge_on_d_r) begin
         blank_cnt_nxt = BLANKING_CYC;
      end else if (blank_active) begin
         blank_cnt_nxt = blank_cnt_r - 32'h1;
      end
      period_cnt_nxt = 32'h0;
      duty_nxt = charger_protection_pkg::DUTY_FULL;
      if (lim_act && !blank_active) begin
         duty_nxt = duty_r;
         if (period_cnt_r == CONTROL_PERIOD_CYC - 1) begin
            period_cnt_nxt = 32'h0;
         end else begin
            period_cnt_nxt = period_cnt_r + 32'h1;
         end
         if (period_cnt_r == 32'h0) begin
            duty_nxt = est_duty;
         end
      end
      fault_status_nxt = (ov_fault_nxt || power_budget_select_fault_nxt) ? charger_protection_pkg::FAULT_CHARGER
                                                          : charger_protection_pkg::FAULT_NONE;
      set_flags = 4'h0;
      set_flags[charger_protection_pkg::FAULT_IRQ_BIT] = (ov_now && !ov_fault_r)
                                                         || (power_budget_select_fault_nxt && !power_budget_select_fault_r);
      set_flags[charger_protection_pkg::VBUS_IRQ_BIT] = vbus_ov && !usb_disc_r;
      set_flags[charger_protection_pkg::SHORT_IRQ_BIT] = rev_on && (slow_held || fast_held);
      set_flags[charger_protection_pkg::REVCUR_IRQ_BIT] = rev_on && revcur;
      // FETs act on the synchronised level at once, ahead of any state
      fet_ab_nxt = !ov_now && ((charge_on && (!lim_chop || pwm_on)) || rev_on);
      sys_fet_nxt = system_fet_request || ov_now || ov_fault_r || lim_chop;
      acc_nxt = rev_on && !slow_held && !fast_held && !revcur;
      cur_nxt = charge_on ? setting_r[3:0] : 4'h0;
      volt_nxt = setting_r[charger_protection_pkg::VOLT_LSB +: 3];
      trk_on_nxt = trickle_req || (control_r[charger_protection_pkg::SW_MODE_BIT]
                   && control_r[charger_protection_pkg::TRICKLE_BIT]);
      trk_hi_nxt = !below_min && below_on;
   end

   // Avalon-MM slave: answer one cycle after the request, act on the acked edge
   assign bus_go = (read || write) && !wait_r;
   always_comb begin
      control_nxt = control_r;
      setting_nxt = setting_r;
      mask_nxt = mask_r;
      flags_nxt = flags_r;
      wait_nxt = 1'b1;
      readdata_nxt = readdata_r;
      if ((read || write) && wait_r) begin
         wait_nxt = 1'b0;
         case (address)
            charger_protection_pkg::CONTROL_ADDR: readdata_nxt = {24'h0, control_r};
            charger_protection_pkg::STATUS_ADDR: readdata_nxt = {23'h0, lim_chop, blank_active,
               rev_on, vbus_ov, ov_fault_r, trk_hi_r, serial_path, fault_status_r};
            charger_protection_pkg::IRQ_FLAG_ADDR: readdata_nxt = {28'h0, flags_r};
            charger_protection_pkg::IRQ_MASK_ADDR: readdata_nxt = {28'h0, mask_r};
            charger_protection_pkg::SETTING_ADDR: readdata_nxt = {25'h0, setting_r};
            default: readdata_nxt = 32'h0;
         endcase
      end
      if (bus_go && write && byteenable[0]) begin
         case (address)
            charger_protection_pkg::CONTROL_ADDR: control_nxt = writedata[7:0];
            charger_protection_pkg::IRQ_FLAG_ADDR: flags_nxt = flags_r & ~writedata[3:0];
            charger_protection_pkg::IRQ_MASK_ADDR: mask_nxt = writedata[3:0];
            charger_protection_pkg::SETTING_ADDR: setting_nxt = writedata[6:0];
            default: control_nxt = control_r;
         endcase
      end
      // A new event wins over a clear in the same cycle
      flags_nxt = flags_nxt | set_flags;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         control_r <= charger_protection_pkg::CONTROL_RESET;
         setting_r <= {charger_protection_pkg::VOLT_RESET, charger_protection_pkg::CURRENT_RESET};
         flags_r <= 4'h0;
         mask_r <= charger_protection_pkg::MASK_RESET;
         readdata_r <= 32'h0;
         wait_r <= 1'b1;
         ov_fault_r <= 1'b0;
         power_budget_select_fault_r <= 1'b0;
         rev_fault_r <= 1'b0;
         charge_on_d_r <= 1'b0;
         blank_cnt_r <= 32'h0;
         period_cnt_r <= 32'h0;
         duty_r <= charger_protection_pkg::DUTY_FULL;
         fault_status_r <= charger_protection_pkg::FAULT_NONE;
         fet_ab_r <= 1'b0;
         sys_fet_r <= 1'b0;
         usb_disc_r <= 1'b0;
         acc_r <= 1'b0;
         trk_on_r <= 1'b0;
         trk_hi_r <= 1'b0;
         cur_r <= 4'h0;
         volt_r <= charger_protection_pkg::VOLT_RESET;
         irq_r <= 1'b0;
      end else begin
         control_r <= control_nxt;
         setting_r <= setting_nxt;
         flags_r <= flags_nxt;
         mask_r <= mask_nxt;
         readdata_r <= readdata_nxt;
         wait_r <= wait_nxt;
         ov_fault_r <= ov_fault_nxt;
         power_budget_select_fault_r <= power_budget_select_fault_nxt;
         rev_fault_r <= rev_fault_nxt;
         charge_on_d_r <= charge_on;
         blank_cnt_r <= blank_cnt_nxt;
         period_cnt_r <= period_cnt_nxt;
         duty_r <= duty_nxt;
         fault_status_r <= fault_status_nxt;
         fet_ab_r <= fet_ab_nxt;
         sys_fet_r <= sys_fet_nxt;
         usb_disc_r <= vbus_ov;
         acc_r <= acc_nxt;
         trk_on_r <= trk_on_nxt;
         trk_hi_r <= trk_hi_nxt;
         cur_r <= cur_nxt;
         volt_r <= volt_nxt;
         irq_r <= |(flags_r & ~mask_r);
      end
   end

   assign readdata = readdata_r;
   assign waitrequest = wait_r;
   assign series_pass_fet_a = fet_ab_r;
   assign series_pass_fet_b = fet_ab_r;
   assign battery_system_fet = sys_fet_r;
   assign usb_disconnect = usb_disc_r;
   assign accessory_path_on = acc_r;
   assign trickle_source_on = trk_on_r;
   assign trickle_high_current = trk_hi_r;
   assign charge_current_setting = cur_r;
   assign charge_voltage_setting = volt_r;
   assign charger_irq = irq_r;

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   ov_opens_fets_a: assert property (ov_now |=> !series_pass_fet_a && battery_system_fet)
      else $error("Series FETs not opened on over-voltage");
   ov_resume_wait_a: assert property (ov_fault_r && !ov_absent_held |=> ov_fault_r)
      else $error("Charging resumed before debounce elapsed");
   ov_fault_code_a: assert property ($rose(ov_fault_r) |-> fault_status_r == 2'h1
      && flags_r[0])
      else $error("Over-voltage fault code or flag missing");
   // Software may clear the flag while the over-voltage persists
   vbus_disc_a: assert property (vbus_ov |=> usb_disconnect
      && (flags_r[1] || $past(usb_disconnect)))
      else $error("USB not disconnected on VBUS over-voltage");
   limit_chop_a: assert property (lim_chop && !pwm_on && !ov_now |=> !series_pass_fet_a
      && battery_system_fet)
      else $error("Limiter off-slot did not chop the FETs");
   period_hold_a: assert property (period_cnt_r != 32'h0 && lim_act && !blank_active
      |=> $stable(duty_r))
      else $error("Duty changed inside a control period");
   min_duty_fault_a: assert property (lim_act && est_duty == 4'h0 |=> power_budget_select_fault_r
      ##1 charge_current_setting == 4'h0)
      else $error("Limiter fault not raised below minimum duty");
   limiter_off_a: assert property (charge_on && !lim_act && !ov_now |=> series_pass_fet_a)
      else $error("Disabled limiter still chops the FETs");
   short_trip_a: assert property (rev_on && fast_held |=> !accessory_path_on && flags_r[2])
      else $error("Accessory short not handled");
   rev_current_a: assert property (rev_on && revcur |=> !accessory_path_on && flags_r[3])
      else $error("Reverse current not handled");
   irq_mask_a: assert property ((flags_r & ~mask_r) == 4'h0 |=> !charger_irq)
      else $error("Masked or clear flags drove the interrupt");

   ov_seen_c: cover property (ov_now ##1 ov_fault_r ##[1:20] !ov_fault_r);
   short_seen_c: cover property (rev_on ##1 fast_held);
   limiter_fault_c: cover property (lim_act ##1 power_budget_select_fault_r);
endmodule : charger_protection_control
`default_nettype wire

// ---- charger_protection_control_tb.sv ----
// Testbench for the charger protection control block.
// Assumes the shortened timing parameters; every access waits on waitrequest.
`timescale 1ns/1ps
`default_nettype none
module charger_protection_control_tb;
   localparam int unsigned DEB = 20;
   localparam logic [7:0] CTL = charger_protection_pkg::CONTROL_ADDR;
   localparam logic [7:0] STA = charger_protection_pkg::STATUS_ADDR;
   localparam logic [7:0] FLG = charger_protection_pkg::IRQ_FLAG_ADDR;
   localparam logic [7:0] MSK = charger_protection_pkg::IRQ_MASK_ADDR;
   localparam logic [7:0] SET = charger_protection_pkg::SETTING_ADDR;
   logic clk = 0, reset = 1, read = 0, write = 0, waitrequest, irq;
   logic [7:0] address = '0;
   logic [31:0] writedata = '0, readdata, q;
   logic vbus = 0, ov_cmd = 0, s_slow = 0, s_fast = 0, rev_cur = 0, cfg = 1;
   logic raw_ov, bc, bo, fa, fb, fm, usb, acc, tr_on, tr_hi;
   logic [15:0] drop = '0, pwr;
   logic trq = 0, sreq = 0;
   logic [3:0] be = 4'hf;
   logic [15:0] batt = 16'h0fa0;
   logic [3:0] cur;
   logic [2:0] volt;
   int error_cnt = 0, n_compared = 0;
   charger_protection_control #(.OV_DEBOUNCE_CYC(DEB), .CONTROL_PERIOD_CYC(100),
      .BLANKING_CYC(50), .SLOW_SHORT_CYC(20), .FAST_SHORT_CYC(5)) DUT (
      .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(be), .readdata(readdata),
      .waitrequest(waitrequest), .raw_charger_overvoltage(raw_ov),
      .vbus_overvoltage(vbus), .pass_power_mw(pwr), .short_slow_threshold(s_slow),
      .short_fast_threshold(s_fast), .accessory_reverse_current(rev_cur),
      .below_safe_charge_threshold(bc), .below_safe_operate_threshold(bo),
      .trickle_request(trq), .system_fet_request(sreq),
      .charge_path_config_sense(cfg), .series_pass_fet_a(fa), .series_pass_fet_b(fb),
      .battery_system_fet(fm), .usb_disconnect(usb), .accessory_path_on(acc),
      .trickle_source_on(tr_on), .trickle_high_current(tr_hi),
      .charge_current_setting(cur), .charge_voltage_setting(volt), .charger_irq(irq));
   charger_supply_model supply (.clk(clk), .batt_mv(batt), .drop_mw(drop),
      .ov_cmd(ov_cmd), .raw_ov(raw_ov), .below_charge(bc), .below_operate(bo),
      .power_mw(pwr));
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      address <= a;
      writedata <= d;
      write <= w;
      read <= !w;
      // Only the watchdog ends a wait that never sees waitrequest low
      do @(posedge clk); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      // One idle edge so a strobe is never dropped and raised in one step
      @(posedge clk);
   endtask : bus
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
      bus(1'b0, a, '0);
      check(nm, q & m, e);
   endtask : rdc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask : cyc
   task automatic wrap_up;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : wrap_up
   initial forever #4 clk = ~clk;
   initial begin
      cyc(20000);
      error_cnt++;
      wrap_up();
   end
   initial begin
      cyc(20);
      reset <= 1'b0;
      cyc(1);
      rdc("control", CTL, 32'hffffffff, 32'h0);
      rdc("setting", SET, 32'hffffffff, 32'h31);
      rdc("mask", MSK, 32'hffffffff, 32'h0);
      rdc("unmapped", 8'h40, 32'hffffffff, 32'h0);
      rdc("sense", STA, 32'h4, 32'h4);
      cfg <= 1'b0;
      cyc(6);
      rdc("sense", STA, 32'h4, 32'h0);
      cfg <= 1'b1;
      $display("Test reset done");
      // Charge settings go in before charging starts; budget select 00 goes in with the enable write
      bus(1'b1, SET, 32'h35);
      bus(1'b1, CTL, 32'h60);
      cyc(6);
      check("current", 32'(cur), 32'h5);
      check("voltage", 32'(volt), 32'h3);
      ov_cmd <= 1'b1;
      cyc(6);
      check("fets open", 32'({fa, fb, fm}), 32'h1);
      rdc("fault status", STA, 32'h3, 32'h1);
      rdc("fault flag", FLG, 32'h1, 32'h1);
      check("irq", 32'(irq), 32'h1);
      ov_cmd <= 1'b0;
      cyc(6);
      check("still open", 32'(fa), 32'h0);
      cyc(DEB);
      check("resumed", 32'({fa, fb}), 32'h3);
      check("restored", 32'(cur), 32'h5);
      be <= 4'he;
      bus(1'b1, SET, 32'h7f);
      be <= 4'hf;
      rdc("low byte off", SET, 32'h7f, 32'h35);
      bus(1'b1, FLG, 32'h1);
      rdc("cleared", FLG, 32'hf, 32'h0);
      check("irq low", 32'(irq), 32'h0);
      bus(1'b1, MSK, 32'h1);
      ov_cmd <= 1'b1;
      cyc(8);
      check("masked irq", 32'(irq), 32'h0);
      rdc("masked flag", FLG, 32'h1, 32'h1);
      ov_cmd <= 1'b0;
      cyc(DEB + 10);
      bus(1'b1, MSK, 32'h0);
      bus(1'b1, FLG, 32'hf);
      vbus <= 1'b1;
      cyc(6);
      check("usb off", 32'(usb), 32'h1);
      rdc("vbus flag", FLG, 32'h2, 32'h2);
      check("vbus irq", 32'(irq), 32'h1);
      vbus <= 1'b0;
      bus(1'b1, FLG, 32'hf);
      $display("Test over-voltage done");
      drop <= 16'h04b0;
      // 600 mW budget chops, 1200 mW does not, disable and factory mode stop it
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, CTL, i == 0 ? 32'h60 : i == 1 ? 32'h66 : i == 2 ? 32'h61 : 32'he0);
         cyc(250);
         rdc("chopping", STA, 32'h100, i == 0 ? 32'h100 : 32'h0);
         if (i == 0) check("battery fet", 32'(fm), 32'h1);
      end
      // 7000 mW cannot fit a 600 mW budget even at 10 % duty
      drop <= 16'h1b58;
      bus(1'b1, CTL, 32'h00);
      bus(1'b1, CTL, 32'h60);
      cyc(4);
      rdc("limit fault", STA, 32'h3, 32'h1);
      rdc("limit flag", FLG, 32'h1, 32'h1);
      check("charge off", 32'({fa, cur}), 32'h0);
      drop <= '0;
      bus(1'b1, CTL, 32'h00);
      bus(1'b1, FLG, 32'hf);
      $display("Test limiter done");
      // Software charging mode with the trickle enable bit, so the trickle source turns on
      bus(1'b1, CTL, 32'h30);
      for (int i = 0; i < 2; i++) begin
         batt <= i ? 16'h0c80 : 16'h0a00;
         cyc(6);
         check("trickle on", 32'(tr_on), 32'h1);
         check("trickle level", 32'(tr_hi), 32'(i));
      end
      bus(1'b1, CTL, 32'h00);
      trq <= 1'b1;
      sreq <= 1'b1;
      cyc(6);
      check("requested trickle", 32'(tr_on), 32'h1);
      check("requested fet", 32'(fm), 32'h1);
      trq <= 1'b0;
      sreq <= 1'b0;
      cyc(6);
      check("trickle off", 32'(tr_on), 32'h0);
      check("fet released", 32'(fm), 32'h0);
      $display("Test trickle done");
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, CTL, 32'h08);
         cyc(6);
         check("path on", 32'(acc), 32'h1);
         {rev_cur, s_fast, s_slow} <= 3'h1 << i;
         cyc(28);
         check("path off", 32'(acc), 32'h0);
         rdc("rev flags", FLG, 32'hc, i == 2 ? 32'h8 : 32'h4);
         {rev_cur, s_fast, s_slow} <= 3'h0;
         bus(1'b1, CTL, 32'h00);
         bus(1'b1, FLG, 32'hf);
      end
      $display("Test reverse done");
      wrap_up();
   end
endmodule : charger_protection_control_tb
`default_nettype wire

// ---- charger_protection_pkg.sv ----
// Package for the charger protection control block: register map, field
// positions, reset values and timing counts.
// Assumes a 125 MHz system clock.
package charger_protection_pkg;

   // Register byte addresses on the Avalon-MM slave
   localparam logic [7:0] CONTROL_ADDR = 8'h00;
   localparam logic [7:0] STATUS_ADDR = 8'h04;
   localparam logic [7:0] IRQ_FLAG_ADDR = 8'h08;
   localparam logic [7:0] IRQ_MASK_ADDR = 8'h0c;
   localparam logic [7:0] SETTING_ADDR = 8'h10;

   // Control register fields
   localparam int LIMITER_DISABLE_BIT = 0;
   localparam int BUDGET_LSB = 1;
   localparam int REVERSE_BIT = 3;
   localparam int TRICKLE_BIT = 4;
   localparam int SW_MODE_BIT = 5;
   localparam int CHARGE_EN_BIT = 6;
   localparam int FACTORY_BIT = 7;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // Setting register: charge current code [3:0], charge voltage code [6:4]
   localparam int VOLT_LSB = 4;
   localparam logic [3:0] CURRENT_RESET = 4'h1;
   localparam logic [2:0] VOLT_RESET = 3'h3;

   // Interrupt flag and mask bits
   localparam int FAULT_IRQ_BIT = 0;
   localparam int VBUS_IRQ_BIT = 1;
   localparam int SHORT_IRQ_BIT = 2;
   localparam int REVCUR_IRQ_BIT = 3;
   localparam logic [3:0] MASK_RESET = 4'h0;

   localparam logic [1:0] FAULT_NONE = 2'h0;
   localparam logic [1:0] FAULT_CHARGER = 2'h1;

   // Power budget in mW per budget select code
   localparam logic [11:0] BUDGET_0_MW = 12'h258;
   localparam logic [11:0] BUDGET_1_MW = 12'h320;
   localparam logic [11:0] BUDGET_2_MW = 12'h3e8;
   localparam logic [11:0] BUDGET_3_MW = 12'h4b0;
   localparam logic [1:0] BUDGET_RESET = 2'h0;

   // Duty cycle in tenths; the minimum is 10 %
   localparam logic [3:0] DUTY_MIN = 4'h1;
   localparam logic [3:0] DUTY_FULL = 4'ha;

   // Timing
   localparam int unsigned CLK_KHZ = 125000;
   localparam int unsigned OV_DEBOUNCE_MS = 10;
   localparam int unsigned CONTROL_PERIOD_MS = 500;
   localparam int unsigned BLANKING_MS = 1500;
   localparam int unsigned SLOW_SHORT_US = 1000;
   localparam int unsigned FAST_SHORT_US = 100;
   localparam int unsigned OV_DEBOUNCE_CYC = OV_DEBOUNCE_MS * CLK_KHZ;
   localparam int unsigned CONTROL_PERIOD_CYC = CONTROL_PERIOD_MS * CLK_KHZ;
   localparam int unsigned BLANKING_CYC = BLANKING_MS * CLK_KHZ;
   localparam int unsigned SLOW_SHORT_CYC = (SLOW_SHORT_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned FAST_SHORT_CYC = (FAST_SHORT_US * CLK_KHZ + 999) / 1000;

endpackage : charger_protection_pkg

// ---- charger_supply_model.sv ----
// Far-side model: charger supply, battery comparators and pass FET power sense.
// Assumes the bench changes its commands just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module charger_supply_model (
   input wire logic clk,
   input wire logic [15:0] batt_mv,
   input wire logic [15:0] drop_mw,
   input wire logic ov_cmd,
   output logic raw_ov,
   output logic below_charge,
   output logic below_operate,
   output logic [15:0] power_mw
);
   // Analog levels move a cycle late, as a real comparator would
   always @(posedge clk) begin
      raw_ov <= ov_cmd;
      below_charge <= batt_mv < 16'h0bb8;
      below_operate <= batt_mv < 16'h0d48;
      // Estimate stays available even while the limiter is disabled
      power_mw <= drop_mw;
   end
endmodule : charger_supply_model
`default_nettype wire

// ---- sync_persist.sv ----
// Two-flop synchroniser with a persistence counter.
// Assumes one clock; the comparator input may change at any time.
`timescale 1ns/1ps
`default_nettype none
module sync_persist #(
   parameter int unsigned COUNT = 1,
   parameter logic INIT = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic comparator,
   output logic level,
   output logic held
);
   logic meta_r;
   logic level_r;
   logic [31:0] cnt_r;
   logic [31:0] cnt_nxt;

   always_comb begin
      if (!level_r) begin
         cnt_nxt = 32'h0;
      end else if (cnt_r != COUNT) begin
         cnt_nxt = cnt_r + 32'h1;
      end else begin
         cnt_nxt = cnt_r;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         meta_r <= INIT;
         level_r <= INIT;
         cnt_r <= 32'h0;
      end else begin
         meta_r <= comparator;
         level_r <= meta_r;
         cnt_r <= cnt_nxt;
      end
   end

   assign level = level_r;
   // Counts only after the synchronised level, never the first flop
   assign held = (cnt_r == COUNT);
endmodule : sync_persist
`default_nettype wire
